/* design/vmcc_pkg.sv */
// Constants for the voltage-mode chopper configuration and control block.
// Assumes a single 100 MHz chip clock and a synchronous active-low reset.
// Operation
// - Select pin XOR select flag; one forbids voltage mode, zero permits it.
// - Leave voltage mode when microstep interval falls below the threshold.
// - 4-bit limit is top nibble of 8-bit amplitude limit applied at mode entry.
// - Autoscale one: current regulator scaling; zero: forward velocity scaling.
// - Autograd one: gradient tuned automatically; zero: user gradient used.
// - Frequency select 0..3 gives fCLK times 2/1024, 2/683, 2/512, 2/410.
// - Each chopper output switches at half the effective PWM frequency.
// - Regulator gain 1..15 gives 0.5 to 7.5 steps per fullstep.
// - User offset feeds forward scaling and seeds offset tuning; zero disables.
// - User gradient feeds forward scaling and seeds gradient tuning.
// - Zero hold current in voltage mode applies standstill coil option 0..3.
// - Read-only regulator correction, max 255, frozen during current chopping.
// - Tuned offset and gradient are readable for monitoring.
// - Off-time zero switches all drivers off; 1..15 enables the driver.
// - Comparator masked after switching for 16, 24, 36 or 54 clocks.
// - Regulation setting kept while in current mode, reused on return.
// - Standstill option waits for delays; regulation frozen at zero target.
package vmcc_pkg;
    localparam int CLK_MHZ = 100;
    // Output periods in clocks: one output cycle spans two PWM cycles
    localparam logic [10:0] PERIOD_SEL0 = 11'h400; // 1024
    localparam logic [10:0] PERIOD_SEL1 = 11'h2AB; // 683
    localparam logic [10:0] PERIOD_SEL2 = 11'h200; // 512
    localparam logic [10:0] PERIOD_SEL3 = 11'h19A; // 410
    // Comparator blank times in clocks
    localparam logic [5:0] BLANK_SEL0 = 6'h10; // 16
    localparam logic [5:0] BLANK_SEL1 = 6'h18; // 24
    localparam logic [5:0] BLANK_SEL2 = 6'h24; // 36
    localparam logic [5:0] BLANK_SEL3 = 6'h36; // 54
    localparam logic [3:0] LIMIT_RESET = 4'hC;  // Default limit nibble
    localparam logic [3:0] LIMIT_LOW_NIBBLE = 4'hF;
    localparam logic [8:0] REG_ACC_MAX = 9'h1FE; // 255 in half steps
    localparam logic [3:0] OFF_TIME_DISABLED = 4'h0;
    // Standstill coil options
    typedef enum logic [1:0] {
        VMCC_SS_NORMAL = 2'h0,
        VMCC_SS_STANDSTILL_COIL_OPTION = 2'h1,
        VMCC_SS_SHORT_LOW = 2'h2,
        VMCC_SS_SHORT_HIGH = 2'h3
    } vmcc_standstill_type;
endpackage

/* design/vmcc_pwm_timer.sv */
// Output-cycle timer and duty comparator for the voltage-mode chopper.
// Assumes amplitude and select come from logic on the same clock.
`timescale 1ns/1ps
module vmcc_pwm_timer
    import vmcc_pkg::*;
(
    input wire logic mclk_in, // Chip clock
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic [1:0] freq_sel_in, // PWM frequency select
    input wire logic [7:0] amplitude_in, // Duty amplitude 0..255
    output logic pwm_out, // Duty waveform
    output logic pwm_cycle_out, // Pulse at each PWM cycle start
    output logic pwm_edge_out // Pulse when pwm_out changes
);
    logic [10:0] phase;
    logic [10:0] period;
    logic [18:0] product;
    logic [10:0] threshold;
    logic last_cycle;
    logic half_point;
    logic next_pwm;

    // Period per select
    assign period = (freq_sel_in == 2'h0) ? PERIOD_SEL0 :
                    (freq_sel_in == 2'h1) ? PERIOD_SEL1 :
                    (freq_sel_in == 2'h2) ? PERIOD_SEL2 : PERIOD_SEL3;
    assign product = 19'(amplitude_in) * 19'(period);
    assign threshold = product[18:8];
    assign last_cycle = (phase >= period - 11'h001);
    assign half_point = (phase == {1'b0, period[10:1]});
    // Output period is two PWM cycles, so it toggles at half fPWM
    assign next_pwm = (phase < threshold);

    // Phase counter, wraps at period end; a select change restarts it through the compare only if the phase is past the new period
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            phase <= 11'h000;
            pwm_out <= 1'b0;
            pwm_cycle_out <= 1'b0;
            pwm_edge_out <= 1'b0;
        end else begin
            phase <= last_cycle ? 11'h000 : phase + 11'h001;
            pwm_out <= next_pwm;
            pwm_cycle_out <= last_cycle | half_point;
            pwm_edge_out <= next_pwm ^ pwm_out;
        end
    end
endmodule

/* design/vmcc_chopper_ctrl.sv */
// Voltage-mode chopper selection, amplitude scaling, regulation, standstill
// handling, driver enable and comparator blanking.
// Assumes the cycle-by-cycle current chopper drives cc_*_in on this clock,
// and that only chopper_select_pin_in arrives asynchronously from a pin.
`timescale 1ns/1ps
module vmcc_chopper_ctrl
    import vmcc_pkg::*;
(
    input wire logic mclk_in, // Chip clock 100 MHz
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic chopper_select_flag_in, // Global config select flag
    input wire logic chopper_select_pin_in, // Select pin, asynchronous
    input wire logic [19:0] microstep_interval_in, // Clocks between usteps
    input wire logic [19:0] voltage_mode_velocity_threshold_in, // Threshold
    input wire logic [3:0] switch_amplitude_limit_in, // Limit nibble
    input wire logic autoscale_in, // Automatic current scaling
    input wire logic autograd_in, // Automatic gradient tuning
    input wire logic [1:0] pwm_frequency_select_in, // PWM frequency code
    input wire logic [3:0] regulator_gain_in, // P gain 1..15
    input wire logic [7:0] user_amplitude_offset_in, // User offset
    input wire logic [7:0] user_amplitude_gradient_in, // User gradient
    input wire logic [1:0] standstill_coil_option_in, // Standstill option
    input wire logic [4:0] hold_current_in, // Hold current setting
    input wire logic [4:0] actual_current_in, // Current setting in use
    input wire logic standstill_delays_done_in, // Power-down, hold delays
    input wire logic motor_standstill_in, // No steps pending
    input wire logic fullstep_in, // Pulse per fullstep
    input wire logic current_below_target_in, // Measured under target
    input wire logic [3:0] off_time_driver_enable_in, // Off time / enable
    input wire logic [1:0] comparator_blank_select_in, // Blank time code
    input wire logic [1:0] cc_high_side_in, // Current chopper HS gates
    input wire logic [1:0] cc_low_side_in, // Current chopper LS gates
    input wire logic cc_switch_in, // Current chopper switched
    output logic [1:0] gate_high_side_out, // HS gates, coil A and B
    output logic [1:0] gate_low_side_out, // LS gates, coil A and B
    output logic comparator_blank_out, // Comparator masked
    output logic voltage_mode_active_out, // Voltage mode running
    output logic [7:0] pwm_amplitude_out, // Applied amplitude
    output logic [7:0] scale_correction_readback_out, // Regulator value
    output logic [7:0] tuned_offset_readback_out, // Tuned offset
    output logic [7:0] tuned_gradient_readback_out // Tuned gradient
);
    logic pin_meta;
    logic pin_sync;
    logic voltage_mode;
    logic entry_limit;
    logic [8:0] reg_acc;
    logic [7:0] ofs_auto;
    logic [7:0] grad_auto;
    logic [5:0] blank_count;
    logic [7:0] amp_q;
    logic [1:0] hs_q;
    logic [1:0] ls_q;

    // Returns a velocity weight from the microstep interval; shorter
    // intervals give larger weights. Coarse, avoids a divider.
    function automatic logic [7:0] velocity_weight(input logic [19:0] iv);
        logic [7:0] w;
        w = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (iv < (20'h00100 << i) && w == 8'h00) begin
                w = 8'hFF >> i;
            end
        end
        return w;
    endfunction

    // Saturating step of a value toward a target
    function automatic logic [7:0] step_toward(input logic [7:0] v,
                                              input logic [7:0] t);
        logic [7:0] r;
        r = v;
        if (v < t) begin
            r = v + 8'h01;
        end else if (v > t) begin
            r = v - 8'h01;
        end
        return r;
    endfunction

    // Pin synchroniser, second stage only is read
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= chopper_select_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Mode selection
    wire select_forbid = pin_sync ^ chopper_select_flag_in;
    wire too_fast = microstep_interval_in <
                    voltage_mode_velocity_threshold_in;
    wire next_voltage_mode = !select_forbid && !too_fast;
    wire entering = next_voltage_mode && !voltage_mode;
    wire driver_on = off_time_driver_enable_in != OFF_TIME_DISABLED;

    // Standstill handling; regulation freezes at zero target current
    wire zero_target = (hold_current_in == 5'h00) && motor_standstill_in;
    wire ss_active = zero_target && voltage_mode &&
                     standstill_delays_done_in;
    wire reg_frozen = !voltage_mode || !autoscale_in ||
                      ss_active;

    // Regulator steps gain/2 per fullstep; at standstill it steps once per
    // PWM cycle instead, so initial standstill regulation can settle.
    wire pwm_raw;
    wire pwm_cycle;
    wire pwm_edge;
    wire reg_tick = motor_standstill_in ? pwm_cycle : fullstep_in;
    wire [9:0] acc_up = {1'b0, reg_acc} + {6'h00, regulator_gain_in};
    wire [8:0] acc_inc = (acc_up > {1'b0, REG_ACC_MAX}) ? REG_ACC_MAX :
                         acc_up[8:0];
    wire [8:0] acc_dec = (reg_acc > {5'h00, regulator_gain_in}) ?
                         reg_acc - {5'h00, regulator_gain_in} : 9'h000;
    wire [8:0] next_acc = current_below_target_in ? acc_inc : acc_dec;
    wire [7:0] scale_now = reg_acc[8:1];

    // Forward-controlled amplitude; zero offset skips current scaling
    wire [12:0] ofs_scaled = 13'(user_amplitude_offset_in) *
                             13'({3'h0, actual_current_in} + 8'h01);
    wire [7:0] ofs_term = (user_amplitude_offset_in == 8'h00) ?
                          8'h00 : ofs_scaled[12:5];
    wire [7:0] grad_sel = autograd_in ? grad_auto :
                          user_amplitude_gradient_in;
    wire [15:0] grad_prod = 16'(grad_sel) *
                            16'(velocity_weight(microstep_interval_in));
    wire [8:0] fwd_sum = {1'b0, ofs_term} + {1'b0, grad_prod[15:8]};
    wire [7:0] fwd_amp = fwd_sum[8] ? 8'hFF : fwd_sum[7:0];
    wire [7:0] auto_amp = scale_now; // Regulator owns the amplitude
    wire [7:0] raw_amp = autoscale_in ? auto_amp : fwd_amp;
    // Limit cuts the current jerk on entry from current chopping
    wire [7:0] limit = {switch_amplitude_limit_in, LIMIT_LOW_NIBBLE};
    wire [7:0] next_amp = (entry_limit && raw_amp > limit) ?
                          limit : raw_amp;

    // Gradient target is the regulator excess above the tuned offset
    wire [7:0] grad_target = (scale_now > ofs_auto) ?
                             scale_now - ofs_auto : 8'h00;

    vmcc_pwm_timer u_timer (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .freq_sel_in(pwm_frequency_select_in),
        .amplitude_in(amp_q),
        .pwm_out(pwm_raw),
        .pwm_cycle_out(pwm_cycle),
        .pwm_edge_out(pwm_edge)
    );

    // Mode flag and entry limit; limit lasts until first regulator tick
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            voltage_mode <= 1'b0;
            entry_limit <= 1'b1;
        end else begin
            voltage_mode <= next_voltage_mode;
            entry_limit <= entering | (entry_limit & !reg_tick);
        end
    end

    // Regulator value kept across current-chopping phases
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            reg_acc <= 9'h000;
        end else if (!reg_frozen && reg_tick) begin
            reg_acc <= next_acc;
        end
    end

    // Tuning: seeded by user values while autoscale is off
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            ofs_auto <= 8'h00;
            grad_auto <= 8'h00;
        end else if (!autoscale_in) begin
            ofs_auto <= user_amplitude_offset_in;
            grad_auto <= user_amplitude_gradient_in;
        end else if (!reg_frozen && reg_tick) begin
            if (motor_standstill_in) begin
                ofs_auto <= step_toward(ofs_auto, scale_now);
            end else if (autograd_in) begin
                grad_auto <= step_toward(grad_auto, grad_target);
            end
        end
    end

    // Gate selection: off, standstill option, voltage PWM, current chopper
    wire ss_low = ss_active &&
                  standstill_coil_option_in == VMCC_SS_SHORT_LOW;
    wire ss_high = ss_active &&
                   standstill_coil_option_in == VMCC_SS_SHORT_HIGH;
    wire ss_free = ss_active &&
                   standstill_coil_option_in == VMCC_SS_STANDSTILL_COIL_OPTION;
    wire ss_override = ss_low || ss_high || ss_free;
    wire [1:0] vm_hs = {pwm_raw, !pwm_raw};
    wire [1:0] vm_ls = {!pwm_raw, pwm_raw};
    wire [1:0] next_hs = !driver_on ? 2'h0 :
                         ss_override ? {2{ss_high}} :
                         voltage_mode ? vm_hs : cc_high_side_in;
    wire [1:0] next_ls = !driver_on ? 2'h0 :
                         ss_override ? {2{ss_low}} :
                         voltage_mode ? vm_ls : cc_low_side_in;

    // Blank length per code
    wire [5:0] blank_len = (comparator_blank_select_in == 2'h0) ? BLANK_SEL0 :
                           (comparator_blank_select_in == 2'h1) ? BLANK_SEL1 :
                           (comparator_blank_select_in == 2'h2) ? BLANK_SEL2 :
                           BLANK_SEL3;
    wire switched = voltage_mode ? pwm_edge : cc_switch_in;
    wire [5:0] next_blank = switched ? blank_len :
                            (blank_count != 6'h00) ?
                            blank_count - 6'h01 : 6'h00;

    // Output registers
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            amp_q <= 8'h00;
            hs_q <= 2'h0;
            ls_q <= 2'h0;
            blank_count <= 6'h00;
        end else begin
            amp_q <= next_amp;
            hs_q <= next_hs;
            ls_q <= next_ls;
            blank_count <= next_blank;
        end
    end

    assign gate_high_side_out = hs_q;
    assign gate_low_side_out = ls_q;
    assign comparator_blank_out = blank_count != 6'h00;
    assign voltage_mode_active_out = voltage_mode;
    assign pwm_amplitude_out = amp_q;
    assign scale_correction_readback_out = scale_now;
    assign tuned_offset_readback_out = ofs_auto;
    assign tuned_gradient_readback_out = grad_auto;
endmodule

/* tb/vmcc_chopper_sva.sv */
// Port checker for the chopper control block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module vmcc_chopper_sva
    import vmcc_pkg::*;
(
    input wire logic mclk_in, // Clock
    input wire logic rst_b_in, // Reset
    input wire logic chopper_select_flag_in, // Flag
    input wire logic chopper_select_pin_in, // Pin
    input wire logic [19:0] microstep_interval_in, // Interval
    input wire logic [19:0] voltage_mode_velocity_threshold_in, // Limit
    input wire logic [1:0] pwm_frequency_select_in, // Freq code
    input wire logic [1:0] standstill_coil_option_in, // Option
    input wire logic [4:0] hold_current_in, // Hold
    input wire logic standstill_delays_done_in, // Delays
    input wire logic motor_standstill_in, // Still
    input wire logic [3:0] off_time_driver_enable_in, // Enable
    input wire logic [1:0] comparator_blank_select_in, // Blank code
    input wire logic cc_switch_in, // Switch
    input wire logic [1:0] gate_high_side_out, // HS
    input wire logic [1:0] gate_low_side_out, // LS
    input wire logic comparator_blank_out, // Blank
    input wire logic voltage_mode_active_out, // Mode
    input wire logic [7:0] pwm_amplitude_out, // Amplitude
    input wire logic [7:0] scale_correction_readback_out // Regulator
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    logic [5:0] bl_cnt, bl_exp;
    logic [10:0] pr_cnt;
    logic bl_arm, pr_ok, pr_skip, pr_hs_q, pin_d1, pin_d2;
    logic [1:0] sel_q;
    logic [7:0] amp_prev;
    // Expected figures and the standstill condition
    wire [3:0] gates = {gate_high_side_out, gate_low_side_out};
    wire [1:0] bs = comparator_blank_select_in;
    wire [5:0] next_bl_exp = bs == 2'h0 ? BLANK_SEL0 : bs == 2'h1 ?
        BLANK_SEL1 : bs == 2'h2 ? BLANK_SEL2 : BLANK_SEL3;
    wire [1:0] fs = sel_q;
    wire [10:0] pr_exp = fs == 2'h0 ? PERIOD_SEL0 : fs == 2'h1 ?
        PERIOD_SEL1 : fs == 2'h2 ? PERIOD_SEL2 : PERIOD_SEL3;
    wire cond_ss = hold_current_in == 5'h00 && motor_standstill_in &&
        standstill_delays_done_in && voltage_mode_active_out &&
        off_time_driver_enable_in != 4'h0;
    // First rise after any disturbance is skipped: it may fall mid-period
    wire pr_keep = voltage_mode_active_out && !cond_ss &&
        amp_prev == pwm_amplitude_out &&
        sel_q == pwm_frequency_select_in && off_time_driver_enable_in != 4'h0;
    wire pr_rise = gate_high_side_out[1] && !pr_hs_q;
    // Blank length and PWM period counters
    always_ff @(posedge mclk_in) begin
        sel_q <= pwm_frequency_select_in;
        pin_d1 <= chopper_select_pin_in;
        pin_d2 <= pin_d1;
        amp_prev <= pwm_amplitude_out;
        pr_hs_q <= gate_high_side_out[1];
        pr_cnt <= pr_rise ? 11'h001 : pr_cnt + 11'h001;
        pr_ok <= pr_rise ? pr_keep && !pr_skip : pr_ok && pr_keep;
        pr_skip <= pr_rise ? !pr_keep : pr_skip || !pr_keep;
        bl_exp <= cc_switch_in ? next_bl_exp : bl_exp;
        bl_cnt <= cc_switch_in ? 6'h00 : bl_cnt + 6'(comparator_blank_out);
        bl_arm <= cc_switch_in ? !voltage_mode_active_out :
            bl_arm && !voltage_mode_active_out;
        if (!rst_b_in) begin
            bl_arm <= 1'b0;
            pr_ok <= 1'b0;
            pr_skip <= 1'b1;
        end
    end
    property p_off;
        off_time_driver_enable_in == 4'h0 |=> gates == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("gates on while disabled");
    property p_leave;
        microstep_interval_in < voltage_mode_velocity_threshold_in
            |=> !voltage_mode_active_out;
    endproperty
    a_leave: assert property (p_leave) else $error("mode kept too fast");
    property p_forbid;
        (chopper_select_flag_in ^ pin_d2) |=> !voltage_mode_active_out;
    endproperty
    a_forbid: assert property (p_forbid) else $error("mode not forbidden");
    property p_enter;
        (!(chopper_select_flag_in ^ pin_d2) &&
            microstep_interval_in >= voltage_mode_velocity_threshold_in)
            |=> voltage_mode_active_out;
    endproperty
    a_enter: assert property (p_enter) else $error("mode not entered");
    property p_freeze;
        (!voltage_mode_active_out)[*2] |=> $stable(scale_correction_readback_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("regulator moved");
    property p_standstill;
        (cond_ss && standstill_coil_option_in != 2'h0)[*2] |=> gates ==
            ($past(standstill_coil_option_in) == 2'h1 ? 4'h0 :
            $past(standstill_coil_option_in) == 2'h2 ? 4'h3 : 4'hC);
    endproperty
    a_standstill: assert property (p_standstill) else $error("bad brake");
    property p_blank;
        $fell(comparator_blank_out) && bl_arm |-> bl_cnt == bl_exp;
    endproperty
    a_blank: assert property (p_blank) else $error("blank length wrong");
    property p_period;
        pr_rise && pr_ok |-> pr_cnt == pr_exp;
    endproperty
    a_period: assert property (p_period) else $error("period wrong");
    cover property (cc_switch_in && bs == 2'h3);
    cover property ($rose(voltage_mode_active_out));
    cover property (cond_ss && standstill_coil_option_in == 2'h2);
endmodule

/* tb/vmcc_bridge_model.sv */
// Coil model behind the gate drivers: charges while coil A is driven.
// Assumes gates are sampled on the chip clock.
`timescale 1ns/1ps
module vmcc_bridge_model (
    input wire logic mclk_in, // Chip clock
    input wire logic [1:0] high_side_in, // HS gates
    input wire logic [1:0] low_side_in, // LS gates
    input wire logic [15:0] target_in, // Coil target level
    output logic below_out // Coil under target
);
    logic [15:0] level = 16'h0000;
    // Charge on drive, leak otherwise; never wraps below zero
    always_ff @(posedge mclk_in) begin
        if (high_side_in[1] && low_side_in[0]) begin
            level <= level + 16'h0001;
        end else if (level != 16'h0000) begin
            level <= level - 16'h0001;
        end
    end
    assign below_out = level < target_in;
endmodule

/* tb/vmcc_chopper_ctrl_tb.sv */
// Self-checking bench for the chopper control block.
// Assumes all inputs are levels sampled on the rising clock.
`timescale 1ns/1ps
module vmcc_chopper_ctrl_tb;
    import vmcc_pkg::*;
    logic mclk_in, rst_b_in, chopper_select_flag_in, chopper_select_pin_in;
    logic [19:0] microstep_interval_in, voltage_mode_velocity_threshold_in;
    logic [3:0] switch_amplitude_limit_in, regulator_gain_in;
    logic [3:0] off_time_driver_enable_in;
    logic autoscale_in, autograd_in, standstill_delays_done_in, cc_switch_in;
    logic motor_standstill_in, fullstep_in, current_below_target_in;
    logic [1:0] pwm_frequency_select_in, standstill_coil_option_in;
    logic [1:0] comparator_blank_select_in, cc_high_side_in, cc_low_side_in;
    logic [7:0] user_amplitude_offset_in, user_amplitude_gradient_in;
    logic [4:0] hold_current_in, actual_current_in;
    logic [1:0] gate_high_side_out, gate_low_side_out;
    logic comparator_blank_out, voltage_mode_active_out;
    logic [7:0] pwm_amplitude_out, scale_correction_readback_out;
    logic [7:0] tuned_offset_readback_out, tuned_gradient_readback_out;
    logic [15:0] coil_target;
    logic [10:0] len;
    int fail_count, compares, n, i;
    logic [19:0] iv_t [4] = '{20'h0007F, 20'h00080, 20'hFFFFE, 20'hFFFFF};
    logic [19:0] th_t [4] = '{20'h00080, 20'h00080, 20'hFFFFF, 20'hFFFFF};
    logic [10:0] pr_t [4] = '{PERIOD_SEL0, PERIOD_SEL1, PERIOD_SEL2, PERIOD_SEL3};
    logic [10:0] bl_t [4] = '{11'h010, 11'h018, 11'h024, 11'h036};
    logic [7:0] ss_t [4] = '{8'h00, 8'h00, 8'h03, 8'h0C};
    vmcc_chopper_ctrl i_vmcc_chopper_ctrl (.*);
    vmcc_bridge_model i_vmcc_bridge_model (.mclk_in(mclk_in),
        .high_side_in(gate_high_side_out), .low_side_in(gate_low_side_out),
        .target_in(coil_target), .below_out(current_below_target_in));
    // Free-running 100 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task cyc(input int k);
        repeat (k) @(negedge mclk_in);
    endtask
    task chk_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_len(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Cycles from one rise of the coil A gate to the next, bounded
    task meas;
        len = 11'h000;
        n = 0;
        while (gate_high_side_out[1] !== 1'b0 && n < 5000) begin cyc(1); n++; end
        while (gate_high_side_out[1] !== 1'b1 && n < 5000) begin cyc(1); n++; end
        while (gate_high_side_out[1] === 1'b1 && n < 5000) begin cyc(1); n++; len++; end
        while (gate_high_side_out[1] === 1'b0 && n < 5000) begin cyc(1); n++; len++; end
    endtask
    task tick;
        fullstep_in = 1'b1;
        cyc(1);
        fullstep_in = 1'b0;
        cyc(3);
    endtask
    task end_sim;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Whole run is near 40k cycles; allow about twice that
    initial begin
        #800000;
        fail_count++;
        end_sim;
    end
    // Main sequence, inputs changed on the falling edge
    initial begin
        {rst_b_in, chopper_select_flag_in, chopper_select_pin_in} = 3'h0;
        {autoscale_in, autograd_in, standstill_delays_done_in} = 3'h0;
        {motor_standstill_in, fullstep_in, cc_switch_in} = 3'h0;
        microstep_interval_in = 20'h00100;
        voltage_mode_velocity_threshold_in = 20'h00080;
        switch_amplitude_limit_in = 4'hF;
        regulator_gain_in = 4'hF;
        off_time_driver_enable_in = 4'h3;
        pwm_frequency_select_in = 2'h0;
        standstill_coil_option_in = 2'h0;
        comparator_blank_select_in = 2'h0;
        cc_high_side_in = 2'h2;
        cc_low_side_in = 2'h1;
        user_amplitude_offset_in = 8'h00;
        user_amplitude_gradient_in = 8'h00;
        hold_current_in = 5'h0A;
        actual_current_in = 5'h1F;
        coil_target = 16'hFFFF;
        fail_count = 0;
        compares = 0;
        cyc(6);
        chk_val(8'({gate_high_side_out, gate_low_side_out}), 8'h00);
        chk_val(8'(voltage_mode_active_out), 8'h00);
        chk_val(scale_correction_readback_out, 8'h00);
        rst_b_in = 1'b1;
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            {chopper_select_flag_in, chopper_select_pin_in} = i[1:0];
            cyc(5);
            chk_val(8'(voltage_mode_active_out), 8'(i[1] == i[0]));
        end
        for (i = 0; i < 4; i++) begin
            microstep_interval_in = iv_t[i];
            voltage_mode_velocity_threshold_in = th_t[i];
            cyc(3);
            chk_val(8'(voltage_mode_active_out), 8'(i[0]));
        end
        $display("mode select test done");
        cyc(10);
        chk_val(pwm_amplitude_out, 8'h00);
        user_amplitude_offset_in = 8'h40;
        cyc(10);
        chk_val(pwm_amplitude_out, 8'h40);
        user_amplitude_gradient_in = 8'h25;
        autograd_in = 1'b1;
        cyc(10);
        chk_val(tuned_offset_readback_out, 8'h40);
        chk_val(tuned_gradient_readback_out, 8'h25);
        {user_amplitude_gradient_in, user_amplitude_offset_in} = 16'h0080;
        $display("forward scaling test done");
        for (i = 0; i < 4; i++) begin
            pwm_frequency_select_in = i[1:0];
            meas;
            meas;
            chk_len(len, pr_t[i]);
        end
        off_time_driver_enable_in = 4'hF;
        meas;
        meas;
        chk_len(len, pr_t[3]);
        off_time_driver_enable_in = 4'h0;
        cyc(3);
        chk_val(8'({gate_high_side_out, gate_low_side_out}), 8'h00);
        off_time_driver_enable_in = 4'h1;
        $display("pwm timing test done");
        {chopper_select_flag_in, chopper_select_pin_in} = 2'h2;
        cyc(5);
        for (i = 0; i < 4; i++) begin
            comparator_blank_select_in = i[1:0];
            cc_switch_in = 1'b1;
            cyc(1);
            cc_switch_in = 1'b0;
            len = 11'h000;
            while (comparator_blank_out === 1'b1 && len < 11'h100) begin cyc(1); len++; end
            chk_len(len, bl_t[i]);
            cyc(5);
        end
        $display("blanking test done");
        chopper_select_flag_in = 1'b0;
        autoscale_in = 1'b1;
        {motor_standstill_in, coil_target} = 17'h10000;
        cyc(26240); // 128 PWM periods at select 3
        {motor_standstill_in, coil_target} = 17'h0FFFF;
        cyc(5);
        repeat (4) tick;
        chk_val(scale_correction_readback_out, 8'h1E);
        coil_target = 16'h0000;
        cyc(3);
        tick;
        chk_val(scale_correction_readback_out, 8'h16);
        chopper_select_flag_in = 1'b1;
        cyc(5);
        repeat (2) tick;
        chk_val(scale_correction_readback_out, 8'h16);
        switch_amplitude_limit_in = 4'h0;
        chopper_select_flag_in = 1'b0;
        cyc(5);
        chk_val(scale_correction_readback_out, 8'h16);
        chk_val(pwm_amplitude_out, 8'h0F);
        $display("regulator test done");
        autoscale_in = 1'b0;
        {hold_current_in, motor_standstill_in, standstill_delays_done_in} = 7'h03;
        for (i = 1; i < 4; i++) begin
            standstill_coil_option_in = i[1:0];
            cyc(4);
            chk_val(8'({gate_high_side_out, gate_low_side_out}), ss_t[i]);
        end
        $display("standstill test done");
        end_sim;
    end
endmodule
bind vmcc_chopper_ctrl vmcc_chopper_sva i_vmcc_chopper_sva (.*);
